// ===== src/twsio_pkg.sv
// Shared constants for the three-wire serial port and its peer
package twsio_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets (APB, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE_CONTROL = 8'h00;
  localparam logic [7:0] OFS_BUS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_SHIFT_REGISTER = 8'h08;
  localparam logic [7:0] OFS_SLAVE_ADDRESS = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MODE_SET = 8'h14;
  localparam logic [7:0] OFS_MODE_CLEAR = 8'h18;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_SERIAL_ENABLE = 7;
  localparam int BIT_ADDRESS_MATCH = 6;
  localparam int BIT_WAKEUP_ENABLE = 5;
  localparam int BIT_IFACE_MODE = 3;
  localparam int BIT_CLOCK_SOURCE = 1;
  localparam int BIT_RELEASE_TRIGGER = 0;
  localparam int BIT_COMMAND_TRIGGER = 1;
  localparam int BIT_DONE_FLAG = 0;
  localparam int BIT_BUSY = 1;
  // ----------------------------------------------------------------
  // Reset values and fixed patterns
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] BUS_CONTROL_RESET = 8'h00;
  localparam logic [4:0] SLAVE_ADDR_HIGH = 5'h18;
  localparam logic [2:0] SLAVE_ADDR_LOW_RESET = 3'h0;
  // ----------------------------------------------------------------
  // Timing: internal serial clock is the system clock divided by 16
  // ----------------------------------------------------------------
  localparam int SCK_DIVIDE = 16;
  localparam int SCK_HALF = SCK_DIVIDE / 2;
  localparam int FRAME_BITS = 8;
endpackage

// ===== src/twsio_link_if.sv
// Three-wire serial link between the port and its peer
`timescale 1ns/10ps
interface twsio_link_if;
  // Serial clock, two-way: each end has output and active-low enable
  logic dev_sck_o;
  logic dev_sck_oe_n;
  logic peer_sck_o;
  logic peer_sck_oe_n;
  logic sck;
  // Serial output of the port, push-pull while enabled
  logic dev_so_o;
  logic dev_so_oe_n;
  logic so;
  // Serial input of the port, driven by the peer
  logic peer_si_o;
  logic si;

  // Line levels; an undriven line is held high by its pull-up
  assign sck = !dev_sck_oe_n ? dev_sck_o : (!peer_sck_oe_n ? peer_sck_o : 1'b1);
  assign so = !dev_so_oe_n ? dev_so_o : 1'b1;
  assign si = peer_si_o;

  modport dev (
    output dev_sck_o, dev_sck_oe_n, dev_so_o, dev_so_oe_n,
    input sck, si
  );
  modport peer (
    output peer_sck_o, peer_sck_oe_n, peer_si_o,
    input sck, so
  );
endinterface

// ===== src/twsio_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module twsio_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg; // First stage, read only by q

  // Both stages reset high: idle level of the serial lines
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '1;
      q <= '1;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // twsio_sync

// ===== src/twsio_peer.sv
// Peer end of the three-wire link: simple byte exchanger
`timescale 1ns/10ps
module twsio_peer
  import twsio_pkg::*;
#(
  parameter int DIVIDE = SCK_DIVIDE
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // User side
  input wire logic [7:0] peer_tx_data,
  input wire logic peer_start,
  input wire logic peer_clk_master,
  output logic [7:0] peer_rx_data,
  output logic peer_done,
  output logic peer_busy,
  // Link
  twsio_link_if.peer link
);
  localparam logic [3:0] HALF_M1 = 4'(DIVIDE / 2 - 1);
  localparam logic [3:0] LAST_BIT = 4'(FRAME_BITS - 1);

  logic [1:0] pin_sync; // Synced {sck, so}
  logic sck_out_reg; // Own generated clock
  logic sck_prev_reg; // Previous line level for edge detect
  logic [3:0] div_cnt_reg; // Half-period counter
  logic [3:0] bit_cnt_reg; // Bits received
  logic [7:0] sr_reg; // Shift register
  logic master_reg; // Clock master while this frame runs
  logic sck_line;
  logic sck_fall;
  logic sck_rise;

  // ----------------------------------------------------------------
  // Pin capture and edge detect
  // ----------------------------------------------------------------
  twsio_sync #(.WIDTH(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({link.sck, link.so}),
    .q(pin_sync)
  );
  // Own clock is used directly; the pin copy lags by two cycles
  assign sck_line = master_reg ? sck_out_reg : pin_sync[1];
  assign sck_fall = sck_prev_reg & ~sck_line;
  assign sck_rise = ~sck_prev_reg & sck_line;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sck_prev_reg <= 1'b1;
    else
      sck_prev_reg <= sck_line;
  end

  // ----------------------------------------------------------------
  // Clock generation when this end is clock master
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_reg <= 4'h0;
      sck_out_reg <= 1'b1;
    end
    else if (peer_busy && master_reg)
    begin
      // Toggle every half period; stops high after the last rise
      if (div_cnt_reg == HALF_M1)
      begin
        div_cnt_reg <= 4'h0;
        sck_out_reg <= ~sck_out_reg;
      end
      else
        div_cnt_reg <= div_cnt_reg + 4'h1;
    end
    else
    begin
      div_cnt_reg <= 4'h0;
      sck_out_reg <= 1'b1;
    end
  end

  // Drive the clock pin only as master
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.peer_sck_o <= 1'b1;
      link.peer_sck_oe_n <= 1'b1;
    end
    else
    begin
      link.peer_sck_o <= sck_out_reg;
      link.peer_sck_oe_n <= ~master_reg;
    end
  end

  // ----------------------------------------------------------------
  // Frame engine: out on falling edge, in on rising edge, MSB first
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sr_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      peer_busy <= 1'b0;
      master_reg <= 1'b0;
      peer_done <= 1'b0;
      peer_rx_data <= 8'h00;
      link.peer_si_o <= 1'b1;
    end
    else
    begin
      peer_done <= 1'b0;
      if (peer_start && !peer_busy)
      begin
        // Arm; a start while busy is ignored
        sr_reg <= peer_tx_data;
        bit_cnt_reg <= 4'h0;
        peer_busy <= 1'b1;
        master_reg <= peer_clk_master;
      end
      else if (peer_busy && sck_fall)
        link.peer_si_o <= sr_reg[7];
      else if (peer_busy && sck_rise)
      begin
        sr_reg <= {sr_reg[6:0], pin_sync[0]};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == LAST_BIT)
        begin
          peer_busy <= 1'b0;
          master_reg <= 1'b0;
          peer_done <= 1'b1;
          peer_rx_data <= {sr_reg[6:0], pin_sync[0]};
        end
      end
    end
  end
endmodule // twsio_peer

// ===== src/twsio_port.sv
// Device end: three-wire clocked serial port with APB registers
`timescale 1ns/10ps
module twsio_port
  import twsio_pkg::*;
#(
  parameter int DIVIDE = SCK_DIVIDE
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link
  twsio_link_if.dev link
);
  localparam logic [3:0] HALF_M1 = 4'(DIVIDE / 2 - 1);
  localparam logic [3:0] LAST_BIT = 4'(FRAME_BITS - 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic serial_enable_reg; // Mode bit 7
  logic wakeup_enable_reg; // Mode bit 5
  logic iface_mode_reg; // Mode bit 3, stored only
  logic clock_source_reg; // Mode bit 1
  logic [2:0] sva_low_reg; // Writable low bits of slave_address
  logic [7:0] sr_reg; // shift_register
  logic so_latch_reg; // Serial output latch
  logic done_flag_reg; // transfer_done_flag
  logic active_reg; // Frame in progress
  logic [3:0] bit_cnt_reg; // Serial clock counter
  logic [3:0] div_cnt_reg; // Half-period divider
  logic sck_out_reg; // Internally generated clock
  logic sck_prev_reg; // Line level one cycle ago
  logic [1:0] pin_sync; // Synced {sck, si}
  logic sck_line;
  logic sck_fall;
  logic sck_rise;
  logic [7:0] slave_address;
  logic [7:0] shift_next;
  logic address_match;
  logic apb_done; // Access phase completes this edge
  logic apb_wr;
  logic wr_shift;
  logic start;
  logic frame_end;
  logic [31:0] rd_data;
  logic rd_err;

  // ----------------------------------------------------------------
  // Pins, line level and edges
  // ----------------------------------------------------------------
  twsio_sync #(.WIDTH(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({link.sck, link.si}),
    .q(pin_sync)
  );
  // Own clock is used as is; the peer's clock only through the syncer
  assign sck_line = clock_source_reg ? sck_out_reg : pin_sync[1];
  assign sck_fall = sck_prev_reg & ~sck_line;
  assign sck_rise = ~sck_prev_reg & sck_line;
  assign slave_address = {SLAVE_ADDR_HIGH, sva_low_reg};
  assign address_match = (slave_address == sr_reg);
  assign shift_next = {sr_reg[6:0], pin_sync[0]};
  assign frame_end = active_reg & sck_rise & (bit_cnt_reg == LAST_BIT);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sck_prev_reg <= 1'b1;
    else
      sck_prev_reg <= sck_line;
  end

  // ----------------------------------------------------------------
  // APB decode: two-cycle access, write lands with pready
  // ----------------------------------------------------------------
  assign apb_done = psel & penable & pready;
  assign apb_wr = apb_done & pwrite;
  assign wr_shift = apb_wr & (paddr == OFS_SHIFT_REGISTER);
  // Start only when enabled and halted or clock high; write while
  // disabled just loads data and never starts later
  assign start = wr_shift & serial_enable_reg & (~active_reg | sck_line);

  // Read mux; unmapped offsets answer with pslverr
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (paddr)
      OFS_MODE_CONTROL:
      begin
        rd_data[BIT_SERIAL_ENABLE] = serial_enable_reg;
        rd_data[BIT_ADDRESS_MATCH] = address_match;
        rd_data[BIT_WAKEUP_ENABLE] = wakeup_enable_reg;
        rd_data[BIT_IFACE_MODE] = iface_mode_reg;
        rd_data[BIT_CLOCK_SOURCE] = clock_source_reg;
      end
      OFS_BUS_CONTROL, OFS_MODE_SET, OFS_MODE_CLEAR: rd_data = 32'h0000_0000;
      OFS_SHIFT_REGISTER: rd_data[7:0] = sr_reg;
      OFS_SLAVE_ADDRESS: rd_data[7:0] = slave_address;
      OFS_STATUS:
      begin
        rd_data[BIT_DONE_FLAG] = done_flag_reg;
        rd_data[BIT_BUSY] = active_reg;
      end
      default: rd_err = 1'b1;
    endcase
  end

  // Answer registers; pready rises one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= rd_err;
      end
      else
        pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // mode_control and slave_address
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {serial_enable_reg, wakeup_enable_reg} <= {MODE_CONTROL_RESET[BIT_SERIAL_ENABLE],
        MODE_CONTROL_RESET[BIT_WAKEUP_ENABLE]};
      iface_mode_reg <= MODE_CONTROL_RESET[BIT_IFACE_MODE];
      clock_source_reg <= MODE_CONTROL_RESET[BIT_CLOCK_SOURCE];
      sva_low_reg <= SLAVE_ADDR_LOW_RESET;
    end
    else if (apb_wr)
    begin
      unique case (paddr)
        // Whole byte; address match position is read-only
        OFS_MODE_CONTROL:
        begin
          serial_enable_reg <= pwdata[BIT_SERIAL_ENABLE];
          wakeup_enable_reg <= pwdata[BIT_WAKEUP_ENABLE];
          iface_mode_reg <= pwdata[BIT_IFACE_MODE];
          clock_source_reg <= pwdata[BIT_CLOCK_SOURCE];
        end
        // Single-bit set and clear of the upper bits
        OFS_MODE_SET:
        begin
          if (pwdata[BIT_SERIAL_ENABLE])
            serial_enable_reg <= 1'b1;
          if (pwdata[BIT_WAKEUP_ENABLE])
            wakeup_enable_reg <= 1'b1;
        end
        OFS_MODE_CLEAR:
        begin
          if (pwdata[BIT_SERIAL_ENABLE])
            serial_enable_reg <= 1'b0;
          if (pwdata[BIT_WAKEUP_ENABLE])
            wakeup_enable_reg <= 1'b0;
        end
        OFS_SLAVE_ADDRESS: sva_low_reg <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Internal clock: divide by DIVIDE, idles high, masked after frame
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_reg <= 4'h0;
      sck_out_reg <= 1'b1;
    end
    else if (active_reg && !start && serial_enable_reg && clock_source_reg)
    begin
      if (div_cnt_reg == HALF_M1)
      begin
        div_cnt_reg <= 4'h0;
        sck_out_reg <= ~sck_out_reg;
      end
      else
        div_cnt_reg <= div_cnt_reg + 4'h1;
    end
    else
    begin
      div_cnt_reg <= 4'h0;
      sck_out_reg <= 1'b1;
    end
  end

  // Pin drivers: clock out only as master, output only while enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.dev_sck_o <= 1'b1;
      link.dev_sck_oe_n <= 1'b1;
      link.dev_so_o <= 1'b0;
      link.dev_so_oe_n <= 1'b1;
    end
    else
    begin
      link.dev_sck_o <= sck_out_reg;
      link.dev_sck_oe_n <= ~clock_source_reg;
      link.dev_so_o <= so_latch_reg;
      link.dev_so_oe_n <= ~serial_enable_reg;
    end
  end

  // ----------------------------------------------------------------
  // Frame control: counter, stop after eight bits
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
    end
    else if (!serial_enable_reg)
    begin
      active_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
    end
    else if (start)
    begin
      active_reg <= 1'b1;
      bit_cnt_reg <= 4'h0;
    end
    else if (frame_end)
    begin
      active_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
    end
    else if (active_reg && sck_rise)
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
  end

  // Shift register: load by write, shift in on rising edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sr_reg <= 8'h00;
    else if (wr_shift && (!active_reg || sck_line))
      sr_reg <= pwdata[7:0];
    else if (active_reg && serial_enable_reg && sck_rise)
      sr_reg <= shift_next;
  end

  // Output latch: MSB on falling edge, triggers force it at any time, even mid-frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      so_latch_reg <= 1'b0;
    else if (apb_wr && paddr == OFS_BUS_CONTROL && pwdata[BIT_RELEASE_TRIGGER])
      so_latch_reg <= 1'b0;
    else if (apb_wr && paddr == OFS_BUS_CONTROL && pwdata[BIT_COMMAND_TRIGGER])
      so_latch_reg <= 1'b1;
    else if (active_reg && serial_enable_reg && sck_fall)
      so_latch_reg <= sr_reg[7];
  end

  // Done flag: set wins over a clear; wake-up needs an address match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_flag_reg <= 1'b0;
    else if (frame_end && serial_enable_reg
             && (!wakeup_enable_reg || shift_next == slave_address))
      done_flag_reg <= 1'b1;
    else if (apb_wr && paddr == OFS_STATUS && pwdata[BIT_DONE_FLAG])
      done_flag_reg <= 1'b0;
  end
endmodule // twsio_port

// ===== bench/twsio_chk.sv
// Link-level assertions for the three-wire serial port and its peer
`timescale 1ns/10ps
module twsio_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link signals
  input wire logic dev_sck_o,
  input wire logic dev_sck_oe_n,
  input wire logic dev_so_oe_n,
  input wire logic peer_sck_oe_n,
  input wire logic sck,
  input wire logic so,
  input wire logic si
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  logic sck_q; // Line level one cycle ago
  logic [4:0] high_run; // Cycles the line has stayed high
  logic [3:0] fall_cnt; // Falling edges in the current frame
  // Previous line level, to spot falling edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sck_q <= 1'b1;
    else
      sck_q <= sck;
  end
  // A long high stretch marks the gap between frames
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      high_run <= 5'h00;
    else if (!sck)
      high_run <= 5'h00;
    else if (high_run != 5'h1f)
      high_run <= high_run + 5'h01;
  end
  // Saturating count so a runaway clock still shows above eight
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fall_cnt <= 4'h0;
    else if (sck_q && !sck && fall_cnt != 4'hf)
      fall_cnt <= fall_cnt + 4'h1;
    else if (high_run >= 5'h0c)
      fall_cnt <= 4'h0;
  end
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence seq_dev_low;
    !dev_sck_o [*8];
  endsequence
  sequence seq_dev_high;
    dev_sck_o [*8];
  endsequence
  sequence seq_line_quiet;
    sck [*8] ##1 sck [*8];
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_sck_low_half: assert property (
    $fell(dev_sck_o) && !dev_sck_oe_n |-> seq_dev_low ##1 dev_sck_o)
    else $error("own serial clock low half is not eight cycles");
  a_sck_high_half: assert property (
    $rose(dev_sck_o) && !dev_sck_oe_n |-> seq_dev_high)
    else $error("own serial clock high half is too short");
  a_frame_eight: assert property (fall_cnt <= 4'h8)
    else $error("more than eight clock pulses in one frame");
  a_mask_after: assert property (
    $rose(sck) && fall_cnt == 4'h8 |-> seq_line_quiet)
    else $error("serial clock not masked after the eighth bit");
  a_so_stable: assert property (
    sck && $past(sck) && fall_cnt >= 4'h1 && fall_cnt <= 4'h7 && !dev_so_oe_n
    && $past(!dev_so_oe_n) |-> $stable(so))
    else $error("serial output moved while clock high");
  a_si_stable: assert property (
    sck && $past(sck) && fall_cnt >= 4'h1 && fall_cnt <= 4'h7 |-> $stable(si))
    else $error("serial input moved while clock high");
  a_one_driver: assert property (dev_sck_oe_n || peer_sck_oe_n)
    else $error("both ends drive the serial clock");
  a_so_driven: assert property (
    !dev_sck_oe_n && fall_cnt >= 4'h1 && fall_cnt <= 4'h7 |-> !dev_so_oe_n)
    else $error("serial output not driven during own frame");
endmodule // twsio_chk

// ===== bench/tb_three_wire_serial_io.sv
// Self-checking bench: port and peer joined over the link
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_three_wire_serial_io
  import twsio_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] peer_tx_data, peer_rx_data, tx, px;
  logic peer_start, peer_clk_master, peer_done, peer_busy;
  int checks, fails, i, n;
  logic [65:0] rd_q[$]; // Expected read: {mask, pslverr and data}
  logic [65:0] note;
  logic [7:0] peer_q[$]; // Bytes the peer should receive
  logic [7:0] pbyte;
  // Free-running 100 MHz clock
  always #5 pclk = ~pclk;
  twsio_link_if link ();
  twsio_port twsio_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.dev));
  twsio_peer twsio_peer_inst (.pclk(pclk), .presetn(presetn),
    .peer_tx_data(peer_tx_data), .peer_start(peer_start),
    .peer_clk_master(peer_clk_master), .peer_rx_data(peer_rx_data),
    .peer_done(peer_done), .peer_busy(peer_busy), .link(link.peer));
  twsio_chk twsio_chk_inst (.pclk(pclk), .presetn(presetn), .dev_sck_o(link.dev_sck_o),
    .dev_sck_oe_n(link.dev_sck_oe_n), .dev_so_oe_n(link.dev_so_oe_n),
    .peer_sck_oe_n(link.peer_sck_oe_n), .sck(link.sck), .so(link.so), .si(link.si));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One APB transfer; a gap cycle after it avoids double assignment
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Timeout ends the run; otherwise one idle edge before the next call
    if (k >= 50)
    begin
      fails++;
      conclude();
    end
    else
      @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  // Read with the expectation noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    logic [31:0] q;
    rd_q.push_back(err ? {33'h100000000, 33'h100000000} : {33'h1ffffffff, 1'b0, e});
    apb(1'b0, a, 32'h0, q);
  endtask
  // Arm the peer with a one-cycle start
  task automatic pulse();
    peer_start <= 1'b1;
    @(posedge pclk);
    peer_start <= 1'b0;
  endtask
  // Poll the done flag, bounded
  task automatic wait_flag();
    logic [31:0] s;
    int k;
    s = 32'h0;
    k = 0;
    while (s[BIT_DONE_FLAG] !== 1'b1 && k < 400)
    begin
      apb(1'b0, OFS_STATUS, 32'h0, s);
      k++;
    end
    if (k >= 400)
    begin
      fails++;
      conclude();
    end
  endtask
  // ----------------------------------------------------------------
  // Monitor: oldest note against each result as it appears
  // ----------------------------------------------------------------
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
    begin
      note = rd_q.pop_front();
      `CHK({pslverr, prdata} & note[65:33], note[32:0])
    end
    if (peer_done === 1'b1 && peer_q.size() > 0)
    begin
      pbyte = peer_q.pop_front();
      `CHK(peer_rx_data, pbyte)
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    peer_tx_data = 8'h00;
    peer_start = 1'b0;
    peer_clk_master = 1'b0;
    checks = 0;
    fails = 0;
    void'($urandom(32'hbad49dcb));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_MODE_CONTROL, 32'h0);
    rd(OFS_BUS_CONTROL, 32'h0);
    rd(OFS_SLAVE_ADDRESS, 32'hc0);
    rd(OFS_STATUS, 32'h0);
    rd(8'h20, 32'h0, 1'b1);
    // Single-bit set and clear, then whole-byte write over the read-only bit
    wr(OFS_MODE_SET, 32'ha0);
    rd(OFS_MODE_CONTROL, 32'ha0);
    wr(OFS_MODE_CLEAR, 32'h80);
    rd(OFS_MODE_CONTROL, 32'h20);
    wr(OFS_MODE_CONTROL, 32'h40);
    rd(OFS_MODE_CONTROL, 32'h0);
    // Address compare with the fixed upper bits
    wr(OFS_SLAVE_ADDRESS, 32'hff);
    rd(OFS_SLAVE_ADDRESS, 32'hc7);
    wr(OFS_SHIFT_REGISTER, 32'hc7);
    rd(OFS_MODE_CONTROL, 32'h40);
    wr(OFS_SLAVE_ADDRESS, 32'h03);
    rd(OFS_MODE_CONTROL, 32'h0);
    // Enabling after the load must not start a frame
    wr(OFS_MODE_SET, 32'h80);
    repeat (40) @(posedge pclk);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_SHIFT_REGISTER, 32'hc7);
    // Output latch triggers: release, command, both (release wins)
    for (i = 0; i < 3; i++)
    begin
      wr(OFS_BUS_CONTROL, i + 1);
      repeat (3) @(posedge pclk);
      `CHK(link.so, (i == 1))
    end
    rd(OFS_BUS_CONTROL, 32'h0);
    // Frames: four with own clock, two with the peer's clock
    for (i = 0; i < 6; i++)
    begin
      tx = $urandom;
      px = $urandom;
      peer_tx_data <= px;
      peer_clk_master <= (i >= 4);
      peer_q.push_back(tx);
      if (i >= 4)
      begin
        wr(OFS_MODE_CONTROL, 32'h80);
        wr(OFS_SHIFT_REGISTER, {24'h0, tx});
        pulse();
      end
      else
      begin
        wr(OFS_MODE_CONTROL, 32'h82);
        pulse();
        wr(OFS_SHIFT_REGISTER, {24'h0, tx});
      end
      wait_flag();
      rd(OFS_STATUS, 32'h1);
      rd(OFS_SHIFT_REGISTER, {24'h0, px});
      if (i < 5)
        wr(OFS_STATUS, 32'h1);
      repeat (20) @(posedge pclk);
    end
    // Disable in mid-frame: stops, keeps the flag, releases the output
    wr(OFS_SHIFT_REGISTER, {24'h0, px});
    pulse();
    repeat (40) @(posedge pclk);
    wr(OFS_MODE_CLEAR, 32'h80);
    rd(OFS_STATUS, 32'h1);
    `CHK(link.dev_so_oe_n, 1'b1)
    n = 0;
    while (peer_busy !== 1'b0 && n < 500)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500)
      fails++;
    conclude();
  end
endmodule // tb_three_wire_serial_io
